// File: hdl/timer_counter_with_capture.sv
// 8-bit timer/event counter/capture unit with an apb register slave
//
// Overview of operation
// - timer mode counts ticks, match clears and interrupts
// - auto-capture copies running count into capture reg, outside capture mode only
// - auto-capture skips the zero after a match
// - event mode counts rising edges of input
// - event mode match checked on falling edge
// - capture mode: falling edge copies count to b
// - rising edge copies count to a, interrupts, clears
// - rise before any fall updates only register a
// - capture overflow loads all ones, interrupts, clears
// - after overflow capture pauses until a is read or run enable is cleared
// - clock select picks divided clock, or pin outside capture mode
// - run enable low stops and clears the counter
// - mode bit picks count or capture operation
// - stop-mode entry clears run enable
`include "timer_consts.svh"

module timer_counter_with_capture
  import timer_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DIV_WIDTH = 15
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  input wire logic stop_mode_req,
  output logic match_irq
);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic reg_sel_type decode(input logic [11:0] addr);
    reg_sel_type s;
    s = sel_none;
    if (addr[1:0] == 2'h0) begin
      case (addr >> `TC_ADDR_SHIFT)
        `TC_IDX_CMP: s = sel_cmp;
        `TC_IDX_CAPB: s = sel_capb;
        `TC_IDX_CTRL: s = sel_ctrl;
        `TC_IDX_STATUS: s = sel_status;
        `TC_IDX_MASK: s = sel_mask;
        `TC_IDX_CONFIG: s = sel_config;
        default: s = sel_none;
      endcase
    end
    return s;
  endfunction

  // one tick every 2^(13 - sel + dv) cycles of the fast clock
  function automatic logic div_tick(input logic [DIV_WIDTH-1:0] div,
                                    input logic [2:0] sel,
                                    input logic dv);
    logic [DIV_WIDTH-1:0] mask;
    int unsigned sh;
    sh = `TC_DIV_BASE_SHIFT - int'(sel) + int'(dv);
    mask = DIV_WIDTH'((1 << sh) - 1);
    return (div & mask) == mask;
  endfunction

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic [DIV_WIDTH-1:0] div_r, div_nxt;
  logic sync1_r, sync1_nxt;
  logic sync2_r, sync2_nxt;
  logic prev_r, prev_nxt;
  logic [WIDTH-1:0] count_r, count_nxt;
  logic [WIDTH-1:0] cmp_r, cmp_nxt;
  logic [WIDTH-1:0] capb_r, capb_nxt;
  logic auto_capture_en_r, auto_capture_en_nxt;
  logic run_r, run_nxt;
  logic [2:0] clksel_r, clksel_nxt;
  mode_type mode_r, mode_nxt;
  logic dv_r, dv_nxt;
  logic susp_r, susp_nxt;
  logic [`TC_IRQ_BITS-1:0] status_r, status_nxt;
  logic [`TC_IRQ_BITS-1:0] mask_r, mask_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  logic rise, fall, tick, cnt_tick, at_max;
  logic ev_match, ev_ovf;
  logic hw_cmp_upd;
  logic wr_acc, rd_setup, rd_acc;
  reg_sel_type sel;
  logic [WIDTH-1:0] count_inc;
  logic [WIDTH-1:0] all_ones;

  // --------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------
  assign sel = decode(paddr);
  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  // read data is loaded at the setup edge, so no wait state is needed
  assign pready = 1'b1;
  assign pslverr = psel & penable & (sel == sel_none);
  assign prdata = prdata_r;
  assign match_irq = |(status_r & mask_r);

  // --------------------------------------------------------------------
  // edges and ticks
  // --------------------------------------------------------------------
  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;
  assign tick = div_tick(div_r, clksel_r, dv_r);
  assign cnt_tick = (clksel_r == `TC_CLK_EXT) ? rise : tick;
  assign all_ones = {WIDTH{1'b1}};
  assign at_max = count_r == all_ones;
  assign count_inc = count_r + WIDTH'(1);

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    div_nxt = div_r + DIV_WIDTH'(1);
    // only the second stage reads the first
    sync1_nxt = external_count_input;
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
    count_nxt = count_r;
    cmp_nxt = cmp_r;
    capb_nxt = capb_r;
    auto_capture_en_nxt = auto_capture_en_r;
    run_nxt = run_r;
    clksel_nxt = clksel_r;
    mode_nxt = mode_r;
    dv_nxt = dv_r;
    susp_nxt = susp_r;
    mask_nxt = mask_r;
    ev_match = 1'b0;
    ev_ovf = 1'b0;
    hw_cmp_upd = 1'b0;
    prdata_nxt = prdata_r;

    // counting core
    if (!run_r) begin
      count_nxt = '0;
      susp_nxt = 1'b0;
    end else if (mode_r == mode_capture) begin
      if (tick) begin
        count_nxt = count_inc;
      end
      // ticks keep running while suspended, so that period is lost
      if (!susp_r) begin
        if (fall) begin
          capb_nxt = count_r;
        end else if (rise) begin
          // rise before any fall leaves capture b untouched
          cmp_nxt = count_r;
          hw_cmp_upd = 1'b1;
          count_nxt = '0;
          ev_match = 1'b1;
        end else if (tick && at_max) begin
          cmp_nxt = all_ones;
          hw_cmp_upd = 1'b1;
          count_nxt = '0;
          ev_ovf = 1'b1;
          susp_nxt = 1'b1;
        end
      end
    end else begin
      if (clksel_r == `TC_CLK_EXT) begin
        if (cnt_tick) begin
          count_nxt = count_inc;
        end else if (fall && count_r == cmp_r) begin
          count_nxt = '0;
          ev_match = 1'b1;
        end
      end else if (cnt_tick) begin
        if (count_r == cmp_r) begin
          count_nxt = '0;
          ev_match = 1'b1;
        end else begin
          count_nxt = count_inc;
        end
      end
      // the zero left by a match is never copied
      if (auto_capture_en_r && count_r != '0) begin
        capb_nxt = count_r;
      end
    end

    // register writes
    if (wr_acc) begin
      case (sel)
        sel_cmp: begin
          // a capture landing in the same cycle beats software
          if (!hw_cmp_upd) begin
            cmp_nxt = pwdata[WIDTH-1:0];
          end
        end
        sel_ctrl: begin
          auto_capture_en_nxt = pwdata[`TC_CTRL_AUTO_CAPTURE_EN];
          run_nxt = pwdata[`TC_CTRL_RUN];
          clksel_nxt = pwdata[`TC_CTRL_CLK_HI:`TC_CTRL_CLK_LO];
          mode_nxt = mode_type'(pwdata[`TC_CTRL_MODE]);
        end
        sel_mask: mask_nxt = pwdata[`TC_IRQ_BITS-1:0];
        sel_config: dv_nxt = pwdata[`TC_CONFIG_DIV];
        default: begin
        end
      endcase
    end
    // stop entry wins over a control write in the same cycle
    if (stop_mode_req) begin
      run_nxt = 1'b0;
    end

    // reading register a re-arms capture and overflow detection
    if (rd_acc && sel == sel_cmp) begin
      susp_nxt = 1'b0;
    end

    // a new event wins over a clear in the same cycle
    status_nxt = status_r;
    if (wr_acc && sel == sel_status) begin
      status_nxt = status_r & ~pwdata[`TC_IRQ_BITS-1:0];
    end
    status_nxt[`TC_IRQ_MATCH] = status_nxt[`TC_IRQ_MATCH] | ev_match;
    status_nxt[`TC_IRQ_OVF] = status_nxt[`TC_IRQ_OVF] | ev_ovf;

    // read data
    if (rd_setup) begin
      case (sel)
        sel_cmp: prdata_nxt = 32'(cmp_r);
        sel_capb: prdata_nxt = 32'(capb_r);
        sel_ctrl: begin
          prdata_nxt = 32'h00000000;
          prdata_nxt[`TC_CTRL_AUTO_CAPTURE_EN] = auto_capture_en_r;
          prdata_nxt[`TC_CTRL_RUN] = run_r;
          prdata_nxt[`TC_CTRL_CLK_HI:`TC_CTRL_CLK_LO] = clksel_r;
          prdata_nxt[`TC_CTRL_MODE] = mode_r;
        end
        sel_status: prdata_nxt = 32'(status_r);
        sel_mask: prdata_nxt = 32'(mask_r);
        sel_config: begin
          prdata_nxt = 32'h00000000;
          prdata_nxt[`TC_CONFIG_DIV] = dv_r;
        end
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      count_r <= '0;
      cmp_r <= WIDTH'(`TC_DATA_RESET);
      capb_r <= WIDTH'(`TC_DATA_RESET);
      auto_capture_en_r <= 1'(`TC_CTRL_RESET >> `TC_CTRL_AUTO_CAPTURE_EN);
      run_r <= 1'(`TC_CTRL_RESET >> `TC_CTRL_RUN);
      clksel_r <= 3'(`TC_CTRL_RESET >> `TC_CTRL_CLK_LO);
      mode_r <= mode_timer_event;
      dv_r <= 1'b0;
      susp_r <= 1'b0;
      status_r <= '0;
      mask_r <= '0;
      prdata_r <= 32'h00000000;
    end else if (ce) begin
      div_r <= div_nxt;
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
      count_r <= count_nxt;
      cmp_r <= cmp_nxt;
      capb_r <= capb_nxt;
      auto_capture_en_r <= auto_capture_en_nxt;
      run_r <= run_nxt;
      clksel_r <= clksel_nxt;
      mode_r <= mode_nxt;
      dv_r <= dv_nxt;
      susp_r <= susp_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      prdata_r <= prdata_nxt;
    end
  end

endmodule

// File: hdl/timer_consts.svh
// offsets, field positions, reset values and timing counts of the timer
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TC_IDX_CMP 12'h01c
`define TC_IDX_CAPB 12'h01d
`define TC_IDX_CTRL 12'h01e
`define TC_IDX_STATUS 12'h01f
`define TC_IDX_MASK 12'h020
`define TC_IDX_CONFIG 12'h021
`define TC_ADDR_SHIFT 2

// ----------------------------------------------------------------------
// control and config register fields
// ----------------------------------------------------------------------
`define TC_CTRL_MODE 0
`define TC_CTRL_CLK_LO 1
`define TC_CTRL_CLK_HI 3
`define TC_CTRL_RUN 4
`define TC_CTRL_AUTO_CAPTURE_EN 6
`define TC_CONFIG_DIV 0

// ----------------------------------------------------------------------
// interrupt status / mask layout
// ----------------------------------------------------------------------
`define TC_IRQ_MATCH 0
`define TC_IRQ_OVF 1
`define TC_IRQ_BITS 2

// ----------------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------------
`define TC_DATA_RESET 8'hff
`define TC_CTRL_RESET 8'h00
`define TC_CLK_EXT 3'h7
`define TC_DIV_BASE_SHIFT 13

`endif

// File: hdl/timer_pkg.sv
// types shared by the timer/counter design
package timer_pkg;

  typedef enum logic {
    mode_timer_event,
    mode_capture
  } mode_type;

  typedef enum logic [2:0] {
    sel_none,
    sel_cmp,
    sel_capb,
    sel_ctrl,
    sel_status,
    sel_mask,
    sel_config
  } reg_sel_type;

endpackage

// File: test/timer_counter_with_capture_monitor.sv
// concurrent checks on the timer's bus and interrupt ports
module timer_counter_with_capture_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_count_input,
  input wire logic stop_mode_req,
  input wire logic match_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc;
  logic rd;
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_READY: assert property (pready)
    else $error("ready low");
  AST_ERR_PHASE: assert property (pslverr |-> acc)
    else $error("error outside access");
  AST_ERR_BAD: assert property (acc && paddr == 12'h100 |-> pslverr)
    else $error("no error on unmapped");
  AST_ERR_OK: assert property (acc && paddr == 12'h078 |-> !pslverr)
    else $error("error on control");
  AST_BAD_ZERO: assert property (rd && paddr == 12'h100 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_UPPER: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_CTRL_GAP: assert property (rd && paddr == 12'h078 |->
    !prdata[7] && !prdata[5]) else $error("control gap bits set");
  // a cleared mask must silence the output whether it is registered or not
  AST_MASK_OFF: assert property (ce && acc && pwrite && paddr == 12'h080 &&
    pwdata[1:0] == 2'h0 |-> ##2 !match_irq) else $error("irq not masked");
  AST_STOP_RUN: assert property (stop_mode_req ##2
    (rd && paddr == 12'h078) |-> !prdata[4]) else $error("run kept");
  C_ERR: cover property (acc && pslverr);
  C_IRQ: cover property ($rose(match_irq));
  C_STOP: cover property (stop_mode_req);
endmodule

bind timer_counter_with_capture timer_counter_with_capture_monitor i_mon (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_count_input(external_count_input),
  .stop_mode_req(stop_mode_req), .match_irq(match_irq));

// File: test/pulse_source.sv
// pulse source driving the counter input pin
module pulse_source (
  input wire logic pclk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = 1'b0;
  // phases shorter than three cycles are stretched to three cycles
  task automatic hold(input logic lvl, input int n);
    pin <= lvl;
    repeat (n < 3 ? 3 : n) @(posedge pclk);
  endtask
endmodule

// File: test/timer_counter_with_capture_bench.sv
// self-checking bench for the timer/counter with capture
module timer_counter_with_capture_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] CMP = 12'h070;
  localparam logic [11:0] CAPB = 12'h074;
  localparam logic [11:0] CTRL = 12'h078;
  localparam logic [11:0] STAT = 12'h07c;
  localparam logic [11:0] MASK = 12'h080;
  localparam logic [11:0] CONF = 12'h084;
  logic pclk, presetn, ce, psel, penable, pwrite, stop_mode_req, pin;
  logic pready, pslverr, match_irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, capb_v;
  int fail_count, samples_checked;
  logic [11:0] ra [7] = '{CMP, CAPB, CTRL, STAT, MASK, 12'h084, 12'h100};
  logic [31:0] rv [7] = '{32'hff, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [6:0] re = 7'h40;
  always #5 pclk = ~pclk;
  timer_counter_with_capture i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_input(pin),
    .stop_mode_req(stop_mode_req), .match_irq(match_irq));
  pulse_source i_src (.pclk(pclk), .pin(pin));
  task automatic chk(input logic [31:0] got, lo, hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: value %h", $time, got);
    end
  endtask
  task automatic chk_bit(input logic got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: flag %b", $time, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0, r, e);
    chk(r, v, v);
  endtask
  task automatic pulse();
    i_src.hold(1'b1, 4);
    i_src.hold(1'b0, 4);
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    final_report();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    stop_mode_req = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 32'h0, r, e);
      chk(r, rv[i], rv[i]);
      chk_bit(e, re[i]);
    end
    apb(1'b1, 12'h100, 32'h5, r, e);
    chk_bit(e, 1'b1);
    wr(CAPB, 32'h12);
    rdc(CAPB, 32'hff);
    wr(CTRL, 32'hff);
    rdc(CTRL, 32'h5f);
    wr(CTRL, 32'h0);
    wr(CMP, 32'h2);
    wr(MASK, 32'h3);
    // third tick cannot come before 257 cycles nor after 384
    wr(CTRL, 32'h1c);
    repeat (240) @(posedge pclk);
    rdc(STAT, 32'h0);
    repeat (160) @(posedge pclk);
    rdc(STAT, 32'h1);
    wr(CTRL, 32'h0);
    wr(STAT, 32'h3);
    // divider select halves once more: third tick in 513..768 cycles
    wr(CONF, 32'h1);
    rdc(CONF, 32'h1);
    wr(CTRL, 32'h1c);
    repeat (500) @(posedge pclk);
    rdc(STAT, 32'h0);
    repeat (280) @(posedge pclk);
    rdc(STAT, 32'h1);
    wr(CTRL, 32'h0);
    wr(STAT, 32'h3);
    wr(CONF, 32'h0);
    wr(CMP, 32'h3);
    wr(CTRL, 32'h4e);
    wr(CTRL, 32'h5e);
    pulse();
    pulse();
    rdc(CAPB, 32'h2);
    i_src.hold(1'b1, 6);
    rdc(STAT, 32'h0);
    rdc(CAPB, 32'h3);
    i_src.hold(1'b0, 6);
    rdc(STAT, 32'h1);
    chk_bit(match_irq, 1'b1);
    rdc(CAPB, 32'h3);
    pulse();
    rdc(CAPB, 32'h1);
    wr(CTRL, 32'h4e);
    wr(CTRL, 32'h5e);
    pulse();
    rdc(CAPB, 32'h1);
    wr(STAT, 32'h1);
    @(posedge pclk);
    chk_bit(match_irq, 1'b0);
    stop_mode_req <= 1'b1;
    @(posedge pclk);
    stop_mode_req <= 1'b0;
    rdc(CTRL, 32'h4e);
    wr(CTRL, 32'h0d);
    wr(CTRL, 32'h1d);
    i_src.hold(1'b1, 40);
    rdc(STAT, 32'h1);
    rdc(CAPB, 32'h1);
    wr(MASK, 32'h0);
    wr(MASK, 32'h3);
    wr(STAT, 32'h3);
    i_src.hold(1'b1, 600);
    i_src.hold(1'b0, 1280);
    apb(1'b0, CAPB, 32'h0, capb_v, e);
    chk(capb_v, 32'h4, 32'h6);
    i_src.hold(1'b1, 40);
    apb(1'b0, CMP, 32'h0, r, e);
    chk(r, 32'he, 32'h10);
    rdc(STAT, 32'h1);
    wr(STAT, 32'h3);
    // long enough for 256 ticks, so the counter wraps while high
    i_src.hold(1'b1, 33500);
    i_src.hold(1'b0, 300);
    i_src.hold(1'b1, 300);
    rdc(STAT, 32'h2);
    rdc(CAPB, capb_v);
    rdc(CMP, 32'hff);
    i_src.hold(1'b0, 300);
    i_src.hold(1'b1, 300);
    rdc(STAT, 32'h3);
    // a write while the clock enable is low must leave the mask alone
    ce <= 1'b0;
    wr(MASK, 32'h0);
    ce <= 1'b1;
    chk_bit(match_irq, 1'b1);
    // reset in mid-run restores the data registers and drops the irq
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_bit(match_irq, 1'b0);
    chk(prdata, 32'h0, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(CMP, 32'hff);
    rdc(CAPB, 32'hff);
    rdc(CTRL, 32'h0);
    final_report();
  end
endmodule
